// ### src/fbpc_pkg.sv
// Constants and types for the flash block protection and commit logic
package fbpc_pkg;
  // Protection level codes (2 bits per 2 kB block)
  localparam logic [1:0] PROT_LEVEL_FULL_ACCESS = 2'h0;
  localparam logic [1:0] PROT_LEVEL_NO_MODIFY = 2'h1;
  localparam logic [1:0] PROT_LEVEL_FETCH_ONLY = 2'h2;
  localparam logic [1:0] PROT_LEVEL_INVALID = 2'h3;
  localparam int BLOCK_BYTES = 2048;
  localparam int BLOCK_SHIFT = 11;
  // Access kinds presented for checking
  localparam logic [1:0] ACC_DATA_READ = 2'h0;
  localparam logic [1:0] ACC_FETCH = 2'h1;
  localparam logic [1:0] ACC_ERASE = 2'h2;
  localparam logic [1:0] ACC_PROGRAM = 2'h3;
  // Clocks-per-microsecond reset value (10 MHz clock)
  localparam logic [7:0] CLOCKS_PER_US_RST = 8'h0a;
  // Nonvolatile write time in microseconds
  localparam int NV_WRITE_US = 20;
  typedef enum logic [3:0] {
    FBPC_IDLE = 4'b0001,
    FBPC_PROT_NV = 4'b0010,
    FBPC_USER_NV = 4'b0100,
    FBPC_DONE = 4'b1000
  } fbpc_state_t;
endpackage

// ### src/fbpc_core.sv
// Flash block protection levels, user words, clock setting and commit sequencer
// Functional notes
// - Keep a protection level per 2 kB block: full access, no modify, fetch only.
// - Full-access block may change to no-modify or fetch-only.
// - No-modify block may change to fetch-only.
// - Fetch-only blocks refuse every further protection change.
// - Relaxing requests fail and leave the stored level unchanged.
// - Uncommitted changes are lost at reset; committed levels return.
// - Accesses that break protection raise the violation interrupt.
// - Protection commit writes current levels permanently.
// - Commit completion signals only after the nonvolatile write finishes.
// - Each commit and user-word operation reports success or failure.
// - Invalid block address or level is rejected with failure.
// - Hold clocks per microsecond; it times only the nonvolatile write.
// - Software can read back the clocks-per-microsecond value.
// - Two user words, 0 and 1, writable with any value.
// - Software can read both user words.
// - User-word commit stores the words permanently.
// - Fetch-only blocks allow fetches only; data reads are blocked.
// - No-modify blocks allow reads and fetches; erase and program refused.
`timescale 1ns/1ps
module fbpc_core #(
  parameter int NUM_BLOCKS = 128,
  parameter int ADDR_W = 18,
  parameter int USER_W = 32,
  parameter int CPU_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Committed state and error flag from the nonvolatile store
  input wire logic [2*NUM_BLOCKS-1:0] nv_prot_levels,
  input wire logic [USER_W-1:0] nv_user_word0,
  input wire logic [USER_W-1:0] nv_user_word1,
  input wire logic nv_hw_error,
  // Protection change request
  input wire logic change_block_protection,
  input wire logic [ADDR_W-1:0] prot_addr,
  input wire logic [1:0] prot_level,
  // Commit requests
  input wire logic commit_block_protection,
  input wire logic commit_user_words,
  // User words
  input wire logic write_user_words,
  input wire logic [USER_W-1:0] user_word0_in,
  input wire logic [USER_W-1:0] user_word1_in,
  // Clocks per microsecond
  input wire logic set_clocks_per_us,
  input wire logic [CPU_W-1:0] clocks_per_us_in,
  // Access check
  input wire logic acc_valid,
  input wire logic [1:0] acc_kind,
  input wire logic [ADDR_W-1:0] acc_addr,
  // Nonvolatile write strobes and data
  output logic nv_prot_write,
  output logic [2*NUM_BLOCKS-1:0] nv_prot_data,
  output logic nv_user_write,
  output logic [USER_W-1:0] nv_user_data0,
  output logic [USER_W-1:0] nv_user_data1,
  // Status and results
  output logic busy,
  output logic op_done,
  output logic op_fail,
  output logic acc_violation_irq,
  output logic [CPU_W-1:0] get_clocks_per_us,
  output logic [USER_W-1:0] read_user_word0,
  output logic [USER_W-1:0] read_user_word1
);
  localparam int BIDX_W = $clog2(NUM_BLOCKS);

  logic [1:0] lvl_r [NUM_BLOCKS];
  logic loaded_r;
  logic [USER_W-1:0] user0_r;
  logic [USER_W-1:0] user1_r;
  logic [CPU_W-1:0] cpu_r;
  fbpc_pkg::fbpc_state_t state_r;
  fbpc_pkg::fbpc_state_t state_nxt;
  logic [CPU_W-1:0] us_div_r;
  logic [15:0] us_cnt_r;
  logic hw_err_r;
  logic irq_r;

  // Block number from a byte address; high bits above the flash are invalid
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a >> fbpc_pkg::BLOCK_SHIFT) < NUM_BLOCKS;
  endfunction
  function automatic logic [BIDX_W-1:0] blk(input logic [ADDR_W-1:0] a);
    return BIDX_W'(a >> fbpc_pkg::BLOCK_SHIFT);
  endfunction

  wire idle = (state_r == fbpc_pkg::FBPC_IDLE);
  wire [1:0] cur_lvl = lvl_r[blk(prot_addr)];
  wire lvl_valid = (prot_level != fbpc_pkg::PROT_LEVEL_INVALID);
  // Only strict tightening passes; asking for the level already held fails
  wire tighten_ok = (cur_lvl == fbpc_pkg::PROT_LEVEL_FULL_ACCESS) ?
                    (prot_level != fbpc_pkg::PROT_LEVEL_FULL_ACCESS) :
                    (cur_lvl == fbpc_pkg::PROT_LEVEL_NO_MODIFY) ?
                    (prot_level == fbpc_pkg::PROT_LEVEL_FETCH_ONLY) :
                    1'b0;
  wire prot_ok = addr_ok(prot_addr) && lvl_valid && tighten_ok;
  // Nothing is taken on the reload edge, or the reload would overwrite it unanswered
  wire do_change = change_block_protection && idle && loaded_r;
  wire do_user = write_user_words && idle && loaded_r;

  // Access check against the live levels
  // Addresses beyond the flash reach no block and never flag
  wire [1:0] acc_lvl = lvl_r[blk(acc_addr)];
  wire acc_bad = acc_valid && addr_ok(acc_addr) && (
    ((acc_lvl == fbpc_pkg::PROT_LEVEL_FETCH_ONLY) &&
     (acc_kind != fbpc_pkg::ACC_FETCH)) ||
    ((acc_lvl == fbpc_pkg::PROT_LEVEL_NO_MODIFY) &&
     ((acc_kind == fbpc_pkg::ACC_ERASE) ||
      (acc_kind == fbpc_pkg::ACC_PROGRAM))));

  // One-microsecond tick from the software clock count
  wire us_tick = (us_div_r == '0);
  wire nv_finished = us_tick && (us_cnt_r == 16'(fbpc_pkg::NV_WRITE_US - 1));

  genvar g;
  generate
    for (g = 0; g < NUM_BLOCKS; g++) begin : g_lvl
      wire blk_we = do_change && prot_ok && (blk(prot_addr) == BIDX_W'(g));
      // Full access lasts only until the committed image reloads one edge later
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          lvl_r[g] <= fbpc_pkg::PROT_LEVEL_FULL_ACCESS;
        end else if (!loaded_r) begin
          lvl_r[g] <= nv_prot_levels[2*g +: 2];
        end else if (blk_we) begin
          lvl_r[g] <= prot_level;
        end
      end
      assign nv_prot_data[2*g +: 2] = lvl_r[g];
    end
  endgenerate

  // Reload committed levels on the first edge after reset release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded_r <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      user0_r <= '0;
      user1_r <= '0;
    end else if (!loaded_r) begin
      user0_r <= nv_user_word0;
      user1_r <= nv_user_word1;
    end else if (do_user) begin
      user0_r <= user_word0_in;
      user1_r <= user_word1_in;
    end
  end

  // Not blocked by busy: a change during a commit alters its length
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_r <= CPU_W'(fbpc_pkg::CLOCKS_PER_US_RST);
    end else if (set_clocks_per_us) begin
      cpu_r <= clocks_per_us_in;
    end
  end

  // Commit sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fbpc_pkg::FBPC_IDLE: begin
        if (loaded_r && commit_block_protection) begin
          state_nxt = fbpc_pkg::FBPC_PROT_NV;
        end else if (loaded_r && commit_user_words) begin
          state_nxt = fbpc_pkg::FBPC_USER_NV;
        end
      end
      fbpc_pkg::FBPC_PROT_NV: begin
        if (nv_finished) begin
          state_nxt = fbpc_pkg::FBPC_DONE;
        end
      end
      fbpc_pkg::FBPC_USER_NV: begin
        if (nv_finished) begin
          state_nxt = fbpc_pkg::FBPC_DONE;
        end
      end
      // One extra cycle so done is seen while busy is still high
      fbpc_pkg::FBPC_DONE: state_nxt = fbpc_pkg::FBPC_IDLE;
      default: state_nxt = fbpc_pkg::FBPC_IDLE;
    endcase
  end

  wire starting = idle && (state_nxt != fbpc_pkg::FBPC_IDLE);
  wire in_nv = (state_r == fbpc_pkg::FBPC_PROT_NV) || (state_r == fbpc_pkg::FBPC_USER_NV);
  wire finish_now = in_nv && nv_finished;
  // A count of zero wraps to the longest microsecond rather than stalling
  wire [CPU_W-1:0] us_reload = cpu_r - CPU_W'(1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= fbpc_pkg::FBPC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Divider restarts at commit start so the first microsecond is a whole one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      us_div_r <= '0;
    end else if (starting || (in_nv && us_tick)) begin
      us_div_r <= us_reload;
    end else if (in_nv) begin
      us_div_r <= us_div_r - CPU_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      us_cnt_r <= '0;
    end else if (starting) begin
      us_cnt_r <= '0;
    end else if (in_nv && us_tick) begin
      us_cnt_r <= us_cnt_r + 16'h0001;
    end
  end

  // Sticky over the whole write: one error cycle anywhere fails the commit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hw_err_r <= 1'b0;
    end else if (starting) begin
      hw_err_r <= 1'b0;
    end else if (in_nv && nv_hw_error) begin
      hw_err_r <= 1'b1;
    end
  end

  // Strobes stay high for the whole write so the store sees one stable image
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_prot_write <= 1'b0;
    end else begin
      nv_prot_write <= (state_nxt == fbpc_pkg::FBPC_PROT_NV);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_user_write <= 1'b0;
    end else begin
      nv_user_write <= (state_nxt == fbpc_pkg::FBPC_USER_NV);
    end
  end

  // Words are frozen at commit start; writes are refused while busy anyway
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_user_data0 <= '0;
      nv_user_data1 <= '0;
    end else if (starting) begin
      nv_user_data0 <= user0_r;
      nv_user_data1 <= user1_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_nxt != fbpc_pkg::FBPC_IDLE);
    end
  end

  // Done pulses once per answered request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_done <= 1'b0;
    end else begin
      op_done <= finish_now || do_change || do_user;
    end
  end

  // Fail holds until the next answer so software may read it late
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_fail <= 1'b0;
    end else if (finish_now) begin
      op_fail <= hw_err_r || nv_hw_error;
    end else if (do_change) begin
      op_fail <= !prot_ok;
    end else if (do_user) begin
      op_fail <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= acc_bad;
    end
  end

  assign acc_violation_irq = irq_r;
  assign get_clocks_per_us = cpu_r;
  assign read_user_word0 = user0_r;
  assign read_user_word1 = user1_r;
endmodule

// ### verification/fbpc_core_asserts.sv
// Assertion checker bound to the flash protection core
`timescale 1ns/1ps
module fbpc_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Requests
  input wire logic change_block_protection,
  input wire logic commit_block_protection,
  input wire logic commit_user_words,
  input wire logic acc_valid,
  input wire logic [1:0] acc_kind,
  // Results
  input wire logic busy,
  input wire logic op_done,
  input wire logic nv_prot_write,
  input wire logic nv_user_write,
  input wire logic acc_violation_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_done_pulse: assert property (busy && op_done |=> !op_done)
    else $error("op_done held too long");
  // The load edge after reset takes no request
  a_change_answer: assert property (
    change_block_protection && !busy && $past(reset_n) |=> op_done)
    else $error("change not answered");
  a_prot_commit: assert property (
    commit_block_protection && !busy && $past(reset_n) |=> busy && nv_prot_write)
    else $error("protection commit not started");
  a_user_commit: assert property (
    commit_user_words && !commit_block_protection && !busy && $past(reset_n)
    |=> busy && nv_user_write)
    else $error("user commit not started");
  a_commit_wait: assert property ($rose(busy) |=> !op_done [*8])
    else $error("commit done too early");
  a_commit_ends: assert property ($rose(busy) |-> ##[1:1000] op_done)
    else $error("commit never done");
  a_busy_ends: assert property (
    busy && op_done && !nv_prot_write && !nv_user_write |=> !busy)
    else $error("busy stuck after done");
  a_irq_cause: assert property (acc_violation_irq |-> $past(acc_valid))
    else $error("violation flagged without access");
  a_fetch_ok: assert property (
    acc_valid && acc_kind == fbpc_pkg::ACC_FETCH |=> !acc_violation_irq)
    else $error("fetch flagged");
endmodule
bind fbpc_core fbpc_checker u_chk (.clk(clk), .reset_n(reset_n),
  .change_block_protection(change_block_protection),
  .commit_block_protection(commit_block_protection), .commit_user_words(commit_user_words),
  .acc_valid(acc_valid), .acc_kind(acc_kind), .busy(busy), .op_done(op_done),
  .nv_prot_write(nv_prot_write), .nv_user_write(nv_user_write),
  .acc_violation_irq(acc_violation_irq));

// ### verification/tb_fbpc_core.sv
// Self-checking bench for the flash protection core
`timescale 1ns/1ps
module tb_fbpc_core;
  logic clk = 1'h0, reset_n = 1'h0, err = 1'h0, chg = 1'h0, cpb = 1'h0, cuw = 1'h0;
  logic wuw = 1'h0, scu = 1'h0, av = 1'h0, npw, nuw, busy, done, fail, irq;
  logic [1:0] pl = '0, ak = '0;
  logic [13:0] pa = '0, aa = '0;
  logic [7:0] nvl = 8'h24, cin = 8'h0a, npd, cpu;
  logic [31:0] w0 = '0, w1 = '0, nu0 = '0, nu1 = '0, nd0, nd1, r0, r1;
  int mismatches = 0, checked = 0;
  int kb[6] = '{1, 1, 1, 2, 2, 0};
  int kk[6] = '{2, 3, 0, 0, 1, 3};
  int kv[6] = '{1, 1, 0, 1, 0, 0};
  int cb[8] = '{1, 1, 1, 2, 0, 3, 0, 4};
  int cl[8] = '{0, 2, 1, 0, 1, 2, 3, 1};
  int cf[8] = '{1, 0, 1, 1, 0, 0, 1, 1};
  fbpc_core #(.NUM_BLOCKS(4), .ADDR_W(14)) DUT (.clk(clk), .reset_n(reset_n),
    .nv_prot_levels(nvl), .nv_user_word0(nu0), .nv_user_word1(nu1), .nv_hw_error(err),
    .change_block_protection(chg), .prot_addr(pa), .prot_level(pl),
    .commit_block_protection(cpb), .commit_user_words(cuw), .write_user_words(wuw),
    .user_word0_in(w0), .user_word1_in(w1), .set_clocks_per_us(scu),
    .clocks_per_us_in(cin), .acc_valid(av), .acc_kind(ak), .acc_addr(aa),
    .nv_prot_write(npw), .nv_prot_data(npd), .nv_user_write(nuw), .nv_user_data0(nd0),
    .nv_user_data1(nd1), .busy(busy), .op_done(done), .op_fail(fail),
    .acc_violation_irq(irq), .get_clocks_per_us(cpu), .read_user_word0(r0),
    .read_user_word1(r1));
  always #50 clk = ~clk;
  // Stands in for the nonvolatile store
  always @(posedge clk) begin
    if (npw === 1'h1)
      nvl <= npd;
    if (nuw === 1'h1) begin
      nu0 <= nd0;
      nu1 <= nd1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset();
    reset_n <= 1'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic change(input int blk, input int lvl, input int bad);
    @(posedge clk);
    chg <= 1'h1;
    pa <= 14'(blk * 2048);
    pl <= 2'(lvl);
    @(posedge clk);
    chg <= 1'h0;
    #1;
    check(done, 1);
    check(fail, bad);
  endtask
  task automatic access(input int blk, input int kind, input int exp);
    @(posedge clk);
    av <= 1'h1;
    ak <= 2'(kind);
    aa <= 14'(blk * 2048 + 4);
    @(posedge clk);
    av <= 1'h0;
    #1;
    check(irq, exp);
  endtask
  task automatic wr_user(input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    wuw <= 1'h1;
    w0 <= a;
    w1 <= b;
    @(posedge clk);
    wuw <= 1'h0;
    #1;
    check(done, 1);
    check(fail, 0);
  endtask
  task automatic set_cpu(input logic [7:0] v);
    @(posedge clk);
    scu <= 1'h1;
    cin <= v;
    @(posedge clk);
    scu <= 1'h0;
    @(posedge clk);
    #1;
    check(cpu, v);
  endtask
  // A change is slipped in while busy; it must leave no trace
  task automatic commit(input logic prot, input logic e, input int bad);
    int i;
    @(posedge clk);
    err <= e;
    cpb <= prot;
    cuw <= !prot;
    @(posedge clk);
    cpb <= 1'h0;
    cuw <= 1'h0;
    chg <= 1'h1;
    pa <= '0;
    pl <= 2'h2;
    @(posedge clk);
    chg <= 1'h0;
    #1;
    check(busy, 1);
    i = 0;
    while (done !== 1'h1 && i < 300) begin
      @(posedge clk);
      #1;
      i++;
    end
    check(i < 300, 1);
    check(fail, bad);
    @(posedge clk);
    #1;
    check(busy, 0);
  endtask
  initial begin
    do_reset();
    check(cpu, 8'h0a);
    check(npd, 8'h24);
    set_cpu(8'h01);
    for (int k = 0; k < 6; k++) access(kb[k], kk[k], kv[k]);
    for (int k = 0; k < 8; k++) change(cb[k], cl[k], cf[k]);
    check(npd, 8'ha9);
    wr_user(32'h1234_5678, 32'h9abc_def0);
    check(r0, 32'h1234_5678);
    check(r1, 32'h9abc_def0);
    commit(1'h1, 1'h0, 0);
    check(npd, 8'ha9);
    commit(1'h0, 1'h0, 0);
    check(nu1, 32'h9abc_def0);
    change(0, 2, 0);
    wr_user(32'h0bad_0001, 32'h0bad_0002);
    do_reset();
    check(npd, 8'ha9);
    check(r0, 32'h1234_5678);
    check(cpu, 8'h0a);
    commit(1'h1, 1'h1, 1);
    stop_test();
  end
  initial begin
    #200_000;
    mismatches++;
    stop_test();
  end
endmodule
